/* File: core/bus_event_trigger_sequencer.sv */
// Our own choices: the address map and register access over APB.
`default_nettype none
module bus_event_trigger_sequencer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire trig_seq_pkg::pins_t target_bus,
  output logic emu_break,
  output logic irq
);
  trig_seq_pkg::state_t st_ff;
  trig_seq_pkg::state_t nxt_st;

  logic txn;
  logic go;
  logic halt_edge;
  logic us_tick;
  logic ms_tick;
  logic wr;
  logic rd;
  logic hit_u;
  logic [1:0] addr_ok;
  logic [1:0] data_ok;
  logic [1:0] type_ok;
  logic [1:0] ext_ok;
  logic [1:0] hit;
  logic [1:0] fire;
  logic [1:0] tick;
  logic [3:0] set_st;
  logic fire_sel;
  logic [31:0] rdata;
  logic rerr;
  trig_seq_pkg::pins_t b;

  always_comb begin
    nxt_st = st_ff;
    hit_u = 1'b0;
    addr_ok = 2'b00;
    data_ok = 2'b00;
    type_ok = 2'b00;
    ext_ok = 2'b00;
    hit = 2'b00;
    fire = 2'b00;
    tick = 2'b00;
    set_st = 4'h0;
    fire_sel = 1'b0;
    rdata = 32'h0000_0000;
    rerr = 1'b0;

    // Bus pins cross into pclk; only the second stage and later are looked at.
    nxt_st.s1 = target_bus;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    b = st_ff.s2;
    txn = b.strobe & ~st_ff.s3.strobe & st_ff.run;
    go = b.start & ~st_ff.s3.start;
    halt_edge = b.halt & ~st_ff.s3.halt & st_ff.run;

    // Time base for the microsecond and millisecond units.
    us_tick = (st_ff.pre_us == 6'(trig_seq_pkg::USEC_CYC - 1));
    ms_tick = us_tick && (st_ff.pre_ms == 10'(trig_seq_pkg::USEC_PER_MSEC - 1));
    nxt_st.pre_us = us_tick ? 6'h00 : st_ff.pre_us + 6'h01;
    if (us_tick) begin
      nxt_st.pre_ms = ms_tick ? 10'h000 : st_ff.pre_ms + 10'h001;
    end

    for (int i = 0; i < 2; i++) begin
      // A field whose enable is clear matches anything; a clear type mask means all bus types.
      addr_ok[i] = ~st_ff.u[i].cmp[trig_seq_pkg::CMP_ADDR_EN]
        | (b.addr == st_ff.u[i].cmp[15:0]);
      data_ok[i] = ~st_ff.u[i].cmp[trig_seq_pkg::CMP_DATA_EN]
        | (b.data == st_ff.u[i].cmp[23:16]);
      type_ok[i] = ((b.btype & st_ff.u[i].qual[3:0]) == st_ff.u[i].qual[3:0]);
      ext_ok[i] = ~st_ff.u[i].qual[trig_seq_pkg::QUAL_EXT_EN]
        | (b.ext == st_ff.u[i].qual[15:8]);
      hit_u = txn & addr_ok[i] & data_ok[i] & type_ok[i] & ext_ok[i];
      hit[i] = hit_u;
      // The prescaler runs free, so the first timed tick after a start may come early.
      case (st_ff.mode)
        trig_seq_pkg::MODE_USEC: begin
          tick[i] = us_tick;
        end
        trig_seq_pkg::MODE_MSEC: begin
          tick[i] = ms_tick;
        end
        default: begin
          tick[i] = txn;
        end
      endcase
      case (st_ff.u[i].phase)
        trig_seq_pkg::PH_ARMED: begin
          if (hit_u) begin
            // A remaining count of one or less means this hit completes the passes.
            if (st_ff.u[i].pass_rem > 16'h0001) begin
              nxt_st.u[i].pass_rem = st_ff.u[i].pass_rem - 16'h0001;
            end else if (st_ff.u[i].dly == 16'h0000) begin
              fire[i] = 1'b1;
            end else begin
              nxt_st.u[i].phase = trig_seq_pkg::PH_DELAY;
              nxt_st.u[i].dly_rem = st_ff.u[i].dly;
            end
          end
        end
        // The delay unit is read at each tick, so a mode change takes effect at once.
        trig_seq_pkg::PH_DELAY: begin
          if (tick[i]) begin
            if (st_ff.u[i].dly_rem <= 16'h0001) begin
              fire[i] = 1'b1;
            end else begin
              nxt_st.u[i].dly_rem = st_ff.u[i].dly_rem - 16'h0001;
            end
          end
        end
        trig_seq_pkg::PH_IDLE: begin
        end
        trig_seq_pkg::PH_DONE: begin
        end
        default: begin
          nxt_st.u[i].phase = trig_seq_pkg::PH_IDLE;
        end
      endcase
      if (fire[i]) begin
        nxt_st.u[i].phase = trig_seq_pkg::PH_DONE;
      end
    end

    // Select bit 0 enables unit one and bit 1 unit two, so both set breaks on either.
    fire_sel = (fire[0] & st_ff.sel[0]) | (fire[1] & st_ff.sel[1]);

    // General counter.
    if (st_ff.cnt_run) begin
      case (st_ff.mode)
        trig_seq_pkg::MODE_CYCL: begin
          if (txn) begin
            nxt_st.gcount = st_ff.gcount + 32'h0000_0001;
          end
        end
        trig_seq_pkg::MODE_USEC: begin
          if (us_tick) begin
            nxt_st.gcount = st_ff.gcount + 32'h0000_0001;
          end
        end
        trig_seq_pkg::MODE_MSEC: begin
          if (ms_tick) begin
            nxt_st.gcount = st_ff.gcount + 32'h0000_0001;
          end
        end
        trig_seq_pkg::MODE_EVENT_UNIT_ONE: begin
          if (hit[0]) begin
            nxt_st.gcount = st_ff.gcount + 32'h0000_0001;
          end
        end
        trig_seq_pkg::MODE_EVENT_UNIT_TWO: begin
          if (hit[1]) begin
            nxt_st.gcount = st_ff.gcount + 32'h0000_0001;
          end
        end
        default: begin
          nxt_st.gcount = st_ff.gcount;
        end
      endcase
    end

    // Break sources. Without a selected unit, only a halt stops the run.
    if (fire_sel) begin
      nxt_st.cnt_run = 1'b0;
    end
    if (fire_sel || halt_edge) begin
      nxt_st.brk = 1'b1;
      nxt_st.run = 1'b0;
      nxt_st.cnt_run = 1'b0;
    end

    // A program start rearms everything, even if a break was pending.
    if (go) begin
      nxt_st.run = 1'b1;
      nxt_st.brk = 1'b0;
      nxt_st.cnt_run = 1'b1;
      nxt_st.gcount = 32'h0000_0000;
      for (int i = 0; i < 2; i++) begin
        nxt_st.u[i].phase = trig_seq_pkg::PH_ARMED;
        nxt_st.u[i].pass_rem = st_ff.u[i].pass;
        nxt_st.u[i].dly_rem = st_ff.u[i].dly;
      end
    end

    // Status events; a set in the same cycle as a clear wins, so no event is lost.
    set_st[trig_seq_pkg::ST_TRIG1] = fire[0];
    set_st[trig_seq_pkg::ST_TRIG2] = fire[1];
    set_st[trig_seq_pkg::ST_BREAK] = nxt_st.brk & ~st_ff.brk;
    set_st[trig_seq_pkg::ST_HALT] = halt_edge;

    // APB: access phase lasts two cycles; a write acts where pready is seen high, a read is sampled in the cycle before.
    wr = psel & penable & pready & pwrite;
    rd = psel & penable & ~pready & ~pwrite;
    nxt_st.pready = psel & penable & ~st_ff.pready;
    nxt_st.pslverr = 1'b0;
    case (paddr[7:4])
      4'h0: begin
        case (paddr[3:0])
          trig_seq_pkg::OFF_CTRL[3:0]: begin
            rdata = {25'h0, st_ff.mode, 2'h0, st_ff.sel};
          end
          trig_seq_pkg::OFF_STATUS[3:0]: begin
            rdata = {28'h0, st_ff.status};
          end
          trig_seq_pkg::OFF_MASK[3:0]: begin
            rdata = {28'h0, st_ff.mask};
          end
          trig_seq_pkg::OFF_COUNT[3:0]: begin
            rdata = st_ff.gcount;
          end
          default: begin
            rerr = 1'b1;
          end
        endcase
      end
      // Unit registers sit in two blocks of four words; address bit 5 picks the unit.
      trig_seq_pkg::UNIT_BASE_HI, trig_seq_pkg::UNIT_BASE_HI + 4'h1: begin
        case (paddr[3:2])
          trig_seq_pkg::UREG_CMP: begin
            rdata = st_ff.u[paddr[5]].cmp;
          end
          trig_seq_pkg::UREG_QUAL: begin
            rdata = st_ff.u[paddr[5]].qual;
          end
          trig_seq_pkg::UREG_PASS: begin
            rdata = {16'h0000, st_ff.u[paddr[5]].pass};
          end
          default: begin
            rdata = {16'h0000, st_ff.u[paddr[5]].dly};
          end
        endcase
        rerr = (paddr[1:0] != 2'h0);
      end
      default: begin
        rerr = 1'b1;
      end
    endcase
    // An error answer always carries zero data, for a refused write as well as a read.
    if (rerr) begin
      rdata = 32'h0000_0000;
    end
    if (rd || (psel & penable & ~st_ff.pready & rerr)) begin
      nxt_st.prdata = rdata;
    end
    if (psel & penable & ~st_ff.pready) begin
      nxt_st.pslverr = rerr;
    end

    nxt_st.status = st_ff.status | set_st;
    // A refused access changes no register.
    if (wr && !rerr) begin
      case (paddr[7:4])
        4'h0: begin
          case (paddr[3:0])
            trig_seq_pkg::OFF_CTRL[3:0]: begin
              nxt_st.sel = trig_seq_pkg::brk_sel_t'(pwdata[trig_seq_pkg::CTRL_SEL_LSB +: 2]);
              nxt_st.mode =
                trig_seq_pkg::cnt_mode_t'(pwdata[trig_seq_pkg::CTRL_MODE_LSB +: 3]);
            end
            trig_seq_pkg::OFF_STATUS[3:0]: begin
              nxt_st.status = (st_ff.status & ~pwdata[3:0]) | set_st;
            end
            trig_seq_pkg::OFF_MASK[3:0]: begin
              nxt_st.mask = pwdata[3:0];
            end
            default: begin
              nxt_st.mask = st_ff.mask;
            end
          endcase
        end
        default: begin
          case (paddr[3:2])
            trig_seq_pkg::UREG_CMP: begin
              nxt_st.u[paddr[5]].cmp = pwdata;
            end
            trig_seq_pkg::UREG_QUAL: begin
              nxt_st.u[paddr[5]].qual = pwdata;
            end
            trig_seq_pkg::UREG_PASS: begin
              nxt_st.u[paddr[5]].pass = pwdata[15:0];
            end
            default: begin
              nxt_st.u[paddr[5]].dly = pwdata[15:0];
            end
          endcase
        end
      endcase
    end
    nxt_st.irq = |(nxt_st.status & nxt_st.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // The aggregate clear covers every field; the named values state the intended reset.
      st_ff <= '0;
      st_ff.sel <= trig_seq_pkg::SEL_NONE;
      st_ff.mode <= trig_seq_pkg::MODE_CYCL;
      st_ff.mask <= trig_seq_pkg::MASK_RST;
      for (int i = 0; i < 2; i++) begin
        st_ff.u[i].cmp <= trig_seq_pkg::CMP_RST;
        st_ff.u[i].qual <= trig_seq_pkg::QUAL_RST;
        st_ff.u[i].pass <= trig_seq_pkg::CNT16_RST;
        st_ff.u[i].dly <= trig_seq_pkg::CNT16_RST;
        st_ff.u[i].phase <= trig_seq_pkg::PH_IDLE;
      end
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs come straight from the state register, so no decode logic reaches a pin.
  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign emu_break = st_ff.brk;
  assign irq = st_ff.irq;
endmodule
`default_nettype wire

/* File: core/trig_seq_pkg.sv */
`default_nettype none
package trig_seq_pkg;
  localparam int CLK_NS = 20;
  localparam int USEC_NS = 1000;
  localparam int USEC_CYC = (USEC_NS + CLK_NS - 1) / CLK_NS;
  localparam int USEC_PER_MSEC = 1000;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_COUNT = 8'h0C;
  localparam logic [3:0] UNIT_BASE_HI = 4'h1;
  localparam logic [1:0] UREG_CMP = 2'h0;
  localparam logic [1:0] UREG_QUAL = 2'h1;
  localparam logic [1:0] UREG_PASS = 2'h2;
  localparam logic [1:0] UREG_DLY = 2'h3;
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CMP_ADDR_EN = 24;
  localparam int CMP_DATA_EN = 25;
  localparam int QUAL_EXT_EN = 16;
  localparam int ST_TRIG1 = 0;
  localparam int ST_TRIG2 = 1;
  localparam int ST_BREAK = 2;
  localparam int ST_HALT = 3;
  localparam logic [31:0] CMP_RST = 32'h0000_0000;
  localparam logic [31:0] QUAL_RST = 32'h0000_0000;
  localparam logic [15:0] CNT16_RST = 16'h0000;
  localparam logic [3:0] MASK_RST = 4'h0;
  typedef enum logic [1:0] {
    SEL_NONE = 2'b00, SEL_EV1 = 2'b01, SEL_EV2 = 2'b10, SEL_BOTH = 2'b11
  } brk_sel_t;
  typedef enum logic [2:0] {
    MODE_CYCL = 3'b000, MODE_USEC = 3'b001, MODE_MSEC = 3'b010,
    MODE_EVENT_UNIT_ONE = 3'b011, MODE_EVENT_UNIT_TWO = 3'b100
  } cnt_mode_t;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00, PH_ARMED = 2'b01, PH_DELAY = 2'b10, PH_DONE = 2'b11
  } phase_t;
  typedef struct packed {
    logic strobe;
    logic start;
    logic halt;
    logic [15:0] addr;
    logic [7:0] data;
    logic [3:0] btype;
    logic [7:0] ext;
  } pins_t;
  typedef struct packed {
    logic [31:0] cmp;
    logic [31:0] qual;
    logic [15:0] pass;
    logic [15:0] dly;
    logic [15:0] pass_rem;
    logic [15:0] dly_rem;
    phase_t phase;
  } unit_t;
  typedef struct packed {
    pins_t s1;
    pins_t s2;
    pins_t s3;
    brk_sel_t sel;
    cnt_mode_t mode;
    logic [3:0] status;
    logic [3:0] mask;
    unit_t [1:0] u;
    logic [31:0] gcount;
    logic cnt_run;
    logic run;
    logic brk;
    logic [5:0] pre_us;
    logic [9:0] pre_ms;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_t;
endpackage
`default_nettype wire

/* File: verif/bets_checker_assertions.sv */
`default_nettype none
module bets_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire trig_seq_pkg::pins_t target_bus,
  input wire logic emu_break,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] act_ff, start_ff;
  logic [3:0] nxt_act, nxt_start;
  logic timed_ff;
  logic nxt_timed;
  // Saturating ages let the break checks allow for the two-flop input sync.
  always_comb begin
    nxt_act = (act_ff == 4'hF) ? act_ff : act_ff + 4'h1;
    nxt_start = (start_ff == 4'hF) ? start_ff : start_ff + 4'h1;
    if (target_bus.strobe || target_bus.halt) nxt_act = 4'h0;
    if (target_bus.start) nxt_start = 4'h0;
    // In timed modes a delayed break may come long after the last bus activity.
    nxt_timed = timed_ff;
    if (psel && penable && pready && pwrite && paddr == trig_seq_pkg::OFF_CTRL) begin
      nxt_timed = (pwdata[trig_seq_pkg::CTRL_MODE_LSB +: 3] == trig_seq_pkg::MODE_USEC)
        || (pwdata[trig_seq_pkg::CTRL_MODE_LSB +: 3] == trig_seq_pkg::MODE_MSEC);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_ff <= 4'hF;
      start_ff <= 4'hF;
      timed_ff <= 1'b0;
    end else begin
      act_ff <= nxt_act;
      start_ff <= nxt_start;
      timed_ff <= nxt_timed;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence answer_s;
    !pready ##1 pready;
  endsequence
  AST_APB_SECOND_CYCLE: assert property (setup_s |=> answer_s)
    else $error("pready not in second access cycle");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_READY_NEEDS_ACCESS: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  AST_ERR_ZERO_DATA: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response malformed");
  AST_BREAK_AFTER_CAUSE: assert property ($rose(emu_break) |-> act_ff < 4'h8 || timed_ff)
    else $error("break without recent bus activity");
  AST_BREAK_HOLDS: assert property (emu_break && start_ff > 4'h5 |=> emu_break)
    else $error("break dropped without start");
  AST_BREAK_CLEARS: assert property ($fell(emu_break) |-> start_ff < 4'h7)
    else $error("break cleared late or without start");
  AST_IRQ_HOLDS: assert property (irq && !(pready && pwrite) |=> irq)
    else $error("irq fell without a write");
endmodule
bind bus_event_trigger_sequencer bets_checker u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .target_bus(target_bus), .emu_break(emu_break), .irq(irq));
`default_nettype wire

/* File: verif/bets_target_model.sv */
`default_nettype none
module target_model (
  input wire logic pclk,
  output var trig_seq_pkg::pins_t bus
);
  timeunit 1ns;
  timeprecision 1ps;
  initial bus = '0;
  // Address and data are inverted once their hold time ends so stale values never match.
  task automatic txn(input logic [15:0] a, input logic [7:0] d);
    @(posedge pclk);
    bus.addr <= a;
    bus.data <= d;
    bus.btype <= 4'h3;
    repeat (2) @(posedge pclk);
    bus.strobe <= 1'b1;
    repeat (3) @(posedge pclk);
    bus.strobe <= 1'b0;
    @(posedge pclk);
    bus.addr <= ~a;
    bus.data <= ~d;
    repeat (3) @(posedge pclk);
  endtask
  task automatic pulse(input logic is_halt);
    @(posedge pclk);
    bus.start <= !is_halt;
    bus.halt <= is_halt;
    repeat (3) @(posedge pclk);
    bus.start <= 1'b0;
    bus.halt <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

/* File: verif/bus_event_trigger_sequencer_test.sv */
`default_nettype none
module bus_event_trigger_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, emu_break, irq, e;
  trig_seq_pkg::pins_t tbus;
  int err_count = 0;
  int check_count = 0;
  initial forever #10 pclk = ~pclk;
  target_model tgt (.pclk(pclk), .bus(tbus));
  bus_event_trigger_sequencer DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .target_bus(tbus), .emu_break(emu_break), .irq(irq));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin
      err_count++;
      $display("CHECK FAILED %0t pready never came", $time);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      err_count++;
      $display("CHECK FAILED %0t got %h expected %h", $time, g, x);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  task automatic wu(input logic [3:0] u, input logic [1:0] r, input logic [31:0] d);
    apb(1'b1, {u, r, 2'b00}, d);
  endtask
  task automatic rng(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
    apb(1'b0, a, 32'h0);
    check_count++;
    if ($isunknown(q) || q < lo || q > hi) begin
      err_count++;
      $display("CHECK FAILED %0t got %h expected %h to %h", $time, q, lo, hi);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge pclk);
    err_count++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    final_report;
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(trig_seq_pkg::OFF_CTRL, 32'h0);
    rd(trig_seq_pkg::OFF_MASK, 32'h0);
    apb(1'b0, 8'hFC, 32'h0);
    chk(e, 32'h1);
    wu(4'h1, trig_seq_pkg::UREG_CMP, 32'h037D_0209);
    wu(4'h1, trig_seq_pkg::UREG_PASS, 32'h3);
    apb(1'b1, trig_seq_pkg::OFF_MASK, 32'h1);
    apb(1'b1, trig_seq_pkg::OFF_CTRL, 32'h31);
    tgt.pulse(1'b0);
    tgt.txn(16'h0209, 8'h7D);
    tgt.txn(16'h0300, 8'h00);
    tgt.txn(16'h0209, 8'h7D);
    chk(emu_break, 32'h0);
    tgt.txn(16'h0209, 8'h7D);
    chk(emu_break, 32'h1);
    tgt.txn(16'h0209, 8'h7D);
    rd(trig_seq_pkg::OFF_COUNT, 32'h3);
    chk(irq, 32'h1);
    apb(1'b1, trig_seq_pkg::OFF_STATUS, 32'hF);
    chk(irq, 32'h0);
    wu(4'h2, trig_seq_pkg::UREG_CMP, 32'h0300_0300);
    apb(1'b1, trig_seq_pkg::OFF_CTRL, 32'h40);
    tgt.pulse(1'b0);
    tgt.txn(16'h0300, 8'h00);
    tgt.txn(16'h0209, 8'h7D);
    tgt.txn(16'h0300, 8'h00);
    chk(emu_break, 32'h0);
    rd(trig_seq_pkg::OFF_COUNT, 32'h2);
    tgt.pulse(1'b1);
    chk(emu_break, 32'h1);
    apb(1'b0, trig_seq_pkg::OFF_STATUS, 32'h0);
    chk(q[3], 32'h1);
    chk(irq, 32'h0);
    apb(1'b1, trig_seq_pkg::OFF_STATUS, 32'hF);
    wu(4'h2, trig_seq_pkg::UREG_PASS, 32'h3);
    wu(4'h2, trig_seq_pkg::UREG_PASS, 32'h0);
    wu(4'h2, trig_seq_pkg::UREG_DLY, 32'h5);
    wu(4'h2, trig_seq_pkg::UREG_DLY, 32'h2);
    apb(1'b1, trig_seq_pkg::OFF_CTRL, 32'h02);
    tgt.pulse(1'b0);
    tgt.txn(16'h0300, 8'h00);
    tgt.txn(16'h0209, 8'h00);
    chk(emu_break, 32'h0);
    tgt.txn(16'h0209, 8'h00);
    chk(emu_break, 32'h1);
    wu(4'h1, trig_seq_pkg::UREG_PASS, 32'h2);
    wu(4'h1, trig_seq_pkg::UREG_DLY, 32'h1);
    apb(1'b1, trig_seq_pkg::OFF_CTRL, 32'h01);
    tgt.pulse(1'b0);
    tgt.txn(16'h0209, 8'h7D);
    tgt.txn(16'h0209, 8'h00);
    tgt.txn(16'h0209, 8'h7D);
    chk(emu_break, 32'h0);
    tgt.txn(16'h0300, 8'h00);
    chk(emu_break, 32'h1);
    apb(1'b1, trig_seq_pkg::OFF_CTRL, 32'h13);
    tgt.pulse(1'b0);
    tgt.txn(16'h0300, 8'h00);
    chk(emu_break, 32'h0);
    repeat (300) @(posedge pclk);
    chk(emu_break, 32'h1);
    rng(trig_seq_pkg::OFF_COUNT, 32'h2, 32'h3);
    apb(1'b1, trig_seq_pkg::OFF_CTRL, 32'h20);
    tgt.pulse(1'b0);
    repeat (50100) @(posedge pclk);
    rng(trig_seq_pkg::OFF_COUNT, 32'h1, 32'h2);
    final_report;
  end
endmodule
`default_nettype wire
